//--- design/gpps_defs.svh
`ifndef GPPS_DEFS_SVH
`define GPPS_DEFS_SVH
`define GPPS_SEL_P0 3'h0
`define GPPS_SEL_P1 3'h1
`define GPPS_SEL_P2 3'h2
`define GPPS_SEL_P3 3'h3
`define GPPS_SEL_P4 3'h4
`define GPPS_SEL_P5 3'h5
`define GPPS_SEL_P6 3'h6
`define GPPS_SEL_P7 3'h7
`define GPPS_REG_LATCH 2'h0
`define GPPS_REG_DIR 2'h1
`define GPPS_REG_PU 2'h2
`define GPPS_DIR_RST 8'hff
`define GPPS_PU_RST 8'h00
`define GPPS_LAT_RST 8'h00
`define GPPS_MASK_P0 8'h0f
`define GPPS_MASK_P2 8'h3f
`define GPPS_MASK_P3 8'h7f
`define GPPS_MASK_P6 8'hf0
`define GPPS_MASK_P7 8'h3f
`define GPPS_PU_MASK_P3 8'h70
`define GPPS_OD_MASK_P3 8'h0f
`define GPPS_OD_MASK_P3_TW 8'h03
`define GPPS_FIX_PU_P3 8'h0f
`define GPPS_FIX_PU_P3_TW 8'h03
`endif

//--- design/gpps_pkg.sv
`default_nettype none
package gpps_pkg;
   typedef struct packed {
      logic wr;
      logic rd;
      logic bit_mode;
      logic [2:0] port;
      logic [1:0] reg_sel;
      logic [2:0] bit_idx;
      logic [7:0] wdata;
   } gpps_req_type;
   typedef struct packed {
      logic [7:0] out_val;
      logic [7:0] oe_n;
      logic [7:0] pu_en;
   } gpps_pin_type;
   typedef enum logic {
      GPPS_VAR_BASE,
      GPPS_VAR_TWO_WIRE
   } gpps_var_type;
endpackage : gpps_pkg
`default_nettype wire

//--- design/gpps_port_bank.sv
`include "gpps_defs.svh"
`default_nettype none
// one 8-bit latched port: output latch, direction, pull-up registers
module gpps_port_bank #(
   parameter logic [7:0] IMPL_MASK = 8'hff,
   parameter logic [7:0] PU_MASK = 8'hff
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic wr_en,
   input wire logic bit_mode,
   input wire logic [1:0] reg_sel,
   input wire logic [2:0] bit_idx,
   input wire logic [7:0] wdata,
   output logic [7:0] latch_q,
   output logic [7:0] dir_q,
   output logic [7:0] pu_q
);
   import gpps_pkg::*;

   function automatic logic [7:0] merge(input logic [7:0] old, input logic bm,
                                        input logic [2:0] idx, input logic [7:0] wd);
      logic [7:0] r;
      r = old;
      if (bm) begin
         r[idx] = wd[0];
      end else begin
         r = wd;
      end
      return r;
   endfunction : merge

   wire logic wr_lat = wr_en && reg_sel == `GPPS_REG_LATCH;
   wire logic wr_dir = wr_en && reg_sel == `GPPS_REG_DIR;
   wire logic wr_pu = wr_en && reg_sel == `GPPS_REG_PU;
   wire logic [7:0] lat_d = merge(latch_q, bit_mode, bit_idx, wdata) & IMPL_MASK;
   // unimplemented direction bits read as one, as an input would
   wire logic [7:0] dir_d = merge(dir_q, bit_mode, bit_idx, wdata) | ~IMPL_MASK;
   wire logic [7:0] pu_d = merge(pu_q, bit_mode, bit_idx, wdata) & PU_MASK;

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         latch_q <= `GPPS_LAT_RST;
         dir_q <= `GPPS_DIR_RST;
         pu_q <= `GPPS_PU_RST;
      end else begin
         if (wr_lat) latch_q <= lat_d;
         if (wr_dir) dir_q <= dir_d;
         if (wr_pu) pu_q <= pu_d;
      end
   end
endmodule : gpps_port_bank
`default_nettype wire

//--- design/gpps_top.sv
`include "gpps_defs.svh"
`default_nettype none
module gpps_top #(
   parameter gpps_pkg::gpps_var_type VARIANT = gpps_pkg::GPPS_VAR_BASE
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire gpps_pkg::gpps_req_type req,
   output logic [7:0] rdata_q,
   output logic rvalid_q,
   input wire logic [3:0] p0_in,
   input wire logic [7:0] p1_in,
   input wire logic [5:0] p2_in,
   input wire logic [6:0] p3_in,
   input wire logic [7:0] p4_in,
   input wire logic [7:0] p5_in,
   input wire logic [3:0] p6_in,
   input wire logic [5:0] p7_in,
   output gpps_pkg::gpps_pin_type p0_pin_q,
   output gpps_pkg::gpps_pin_type p2_pin_q,
   output gpps_pkg::gpps_pin_type p3_pin_q,
   output gpps_pkg::gpps_pin_type p4_pin_q,
   output gpps_pkg::gpps_pin_type p5_pin_q,
   output gpps_pkg::gpps_pin_type p6_pin_q,
   output gpps_pkg::gpps_pin_type p7_pin_q,
   output logic [7:0] analog_inputs_q,
   output logic [3:0] ext_interrupt_req_q,
   input wire logic key_interrupt_clr,
   output logic key_interrupt_flag_q
);
   import gpps_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers: all 51 input levels pass two flops
   logic [50:0] sync1_q;
   logic [50:0] sync2_q;
   wire logic [50:0] pins_raw = {p7_in, p6_in, p5_in, p4_in, p3_in, p2_in, p1_in, p0_in};

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         sync1_q <= 51'h0;
         sync2_q <= 51'h0;
      end else begin
         sync1_q <= pins_raw;
         sync2_q <= sync1_q;
      end
   end

   wire logic [7:0] s0 = {4'h0, sync2_q[3:0]};
   wire logic [7:0] s1 = sync2_q[11:4];
   wire logic [7:0] s2 = {2'h0, sync2_q[17:12]};
   wire logic [7:0] s3 = {1'h0, sync2_q[24:18]};
   wire logic [7:0] s4 = sync2_q[32:25];
   wire logic [7:0] s5 = sync2_q[40:33];
   wire logic [7:0] s6 = {sync2_q[44:41], 4'h0};
   wire logic [7:0] s7 = {2'h0, sync2_q[50:45]};

   ////////////////////////////////////////////////////////////////////
   // register banks; port 1 has none since it is input-only
   wire logic [7:0] fix_pu_p3 = (VARIANT == GPPS_VAR_TWO_WIRE) ?
                                `GPPS_FIX_PU_P3_TW : `GPPS_FIX_PU_P3;
   wire logic [7:0] od_p3 = (VARIANT == GPPS_VAR_TWO_WIRE) ?
                            `GPPS_OD_MASK_P3_TW : `GPPS_OD_MASK_P3;

   logic [7:0] lat [8];
   logic [7:0] dir [8];
   logic [7:0] pu [8];

   function automatic logic [7:0] impl_mask(input int p);
      case (p)
         0: return `GPPS_MASK_P0;
         2: return `GPPS_MASK_P2;
         3: return `GPPS_MASK_P3;
         6: return `GPPS_MASK_P6;
         7: return `GPPS_MASK_P7;
         default: return 8'hff;
      endcase
   endfunction : impl_mask

   assign lat[1] = 8'h00;
   assign dir[1] = 8'hff;
   assign pu[1] = 8'h00;

   genvar gp;
   generate
      for (gp = 0; gp < 8; gp++) begin : g_bank
         if (gp != 1) begin : g_impl
            gpps_port_bank #(
               .IMPL_MASK(impl_mask(gp)),
               .PU_MASK(gp == 3 ? `GPPS_PU_MASK_P3 : impl_mask(gp))
            ) u_bank (
               .core_clk(core_clk),
               .nrst(nrst),
               .wr_en(req.wr && req.port == 3'(gp)),
               .bit_mode(req.bit_mode),
               .reg_sel(req.reg_sel),
               .bit_idx(req.bit_idx),
               .wdata(req.wdata),
               .latch_q(lat[gp]),
               .dir_q(dir[gp]),
               .pu_q(pu[gp])
            );
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // pin drive: direction 0 drives, oe_n low while driving
   function automatic gpps_pin_type pin_drive(input logic [7:0] l, input logic [7:0] d,
                                              input logic [7:0] p, input logic [7:0] m,
                                              input logic [7:0] od);
      gpps_pin_type r;
      r.out_val = l & m;
      // open-drain bits only ever pull low: release when latch is one
      r.oe_n = ~(~d & m & ~(od & l));
      r.pu_en = p & m;
      return r;
   endfunction : pin_drive

   wire gpps_pin_type p0_d = pin_drive(lat[0], dir[0], pu[0], `GPPS_MASK_P0, 8'h00);
   wire gpps_pin_type p2_d = pin_drive(lat[2], dir[2], pu[2], `GPPS_MASK_P2, 8'h00);
   wire gpps_pin_type p3_raw = pin_drive(lat[3], dir[3], pu[3], `GPPS_MASK_P3, od_p3);
   wire gpps_pin_type p3_d = '{out_val: p3_raw.out_val, oe_n: p3_raw.oe_n,
                               pu_en: p3_raw.pu_en | fix_pu_p3};
   wire gpps_pin_type p4_d = pin_drive(lat[4], dir[4], pu[4], 8'hff, 8'h00);
   wire gpps_pin_type p5_d = pin_drive(lat[5], dir[5], pu[5], 8'hff, 8'h00);
   wire gpps_pin_type p6_d = pin_drive(lat[6], dir[6], pu[6], `GPPS_MASK_P6, 8'h00);
   wire gpps_pin_type p7_d = pin_drive(lat[7], dir[7], pu[7], `GPPS_MASK_P7, 8'h00);

   ////////////////////////////////////////////////////////////////////
   // read path: input mode shows pin, output mode shows latch
   function automatic logic [7:0] rd_val(input logic [7:0] l, input logic [7:0] d,
                                         input logic [7:0] s);
      return (d & s) | (~d & l);
   endfunction : rd_val

   wire logic [2:0] rp = req.port;
   wire logic [7:0] sel_s = rp == `GPPS_SEL_P0 ? s0 : rp == `GPPS_SEL_P1 ? s1 :
                            rp == `GPPS_SEL_P2 ? s2 : rp == `GPPS_SEL_P3 ? s3 :
                            rp == `GPPS_SEL_P4 ? s4 : rp == `GPPS_SEL_P5 ? s5 :
                            rp == `GPPS_SEL_P6 ? s6 : s7;
   wire logic [7:0] port_val = rd_val(lat[rp], dir[rp], sel_s) & impl_mask(32'(rp));
   wire logic [7:0] reg_val = req.reg_sel == `GPPS_REG_DIR ? dir[rp] :
                              req.reg_sel == `GPPS_REG_PU ? pu[rp] : port_val;
   wire logic [7:0] rd_d = req.bit_mode ? {7'h0, reg_val[req.bit_idx]} : reg_val;

   ////////////////////////////////////////////////////////////////////
   // events
   logic [3:0] p0_drv_q;
   logic [3:0] p0_out_q;
   logic [7:0] s4_prev_q;
   wire logic [3:0] p0_drv = ~dir[0][3:0];
   // level change seen only when output mode held over both cycles
   wire logic [3:0] p0_chg = p0_drv & p0_drv_q & (lat[0][3:0] ^ p0_out_q);
   wire logic key_fall = |(s4_prev_q & ~s4);
   // a fall in the clear cycle wins over the clear
   wire logic key_d = key_fall | (key_interrupt_flag_q & ~key_interrupt_clr);

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         rdata_q <= 8'h00;
         rvalid_q <= 1'b0;
         p0_pin_q <= '0;
         p2_pin_q <= '0;
         p3_pin_q <= '0;
         p4_pin_q <= '0;
         p5_pin_q <= '0;
         p6_pin_q <= '0;
         p7_pin_q <= '0;
         analog_inputs_q <= 8'h00;
         ext_interrupt_req_q <= 4'h0;
         key_interrupt_flag_q <= 1'b0;
         p0_drv_q <= 4'h0;
         p0_out_q <= 4'h0;
         // synchronisers restart at zero: a low start here keeps that from reading as a fall
         s4_prev_q <= 8'h00;
      end else begin
         rdata_q <= req.rd ? rd_d : rdata_q;
         rvalid_q <= req.rd;
         p0_pin_q <= p0_d;
         p2_pin_q <= p2_d;
         p3_pin_q <= p3_d;
         p4_pin_q <= p4_d;
         p5_pin_q <= p5_d;
         p6_pin_q <= p6_d;
         p7_pin_q <= p7_d;
         analog_inputs_q <= s1;
         ext_interrupt_req_q <= p0_chg;
         key_interrupt_flag_q <= key_d;
         p0_drv_q <= p0_drv;
         p0_out_q <= lat[0][3:0];
         s4_prev_q <= s4;
      end
   end
endmodule : gpps_top
`default_nettype wire

//--- test/gpps_pins_model.sv
`default_nettype none
// far side of one port: board drivers plus floating lines
module gpps_pins_model #(
   parameter int W = 4
) (
   input wire logic core_clk,
   input wire gpps_pkg::gpps_pin_type pin,
   input wire logic [W-1:0] ext_en,
   input wire logic [W-1:0] ext_val,
   output logic [W-1:0] lvl
);
   import gpps_pkg::*;
   logic tog = 1'h0;
   logic [W-1:0] oe;
   // a floating line without pull-up toggles so no stale level reads as valid
   always @(posedge core_clk) tog <= ~tog;
   assign oe = ~pin.oe_n[W-1:0];
   assign lvl = (oe & pin.out_val[W-1:0]) | (~oe & ext_en & ext_val)
      | (~oe & ~ext_en & (pin.pu_en[W-1:0] | {W{tog}}));
endmodule : gpps_pins_model
`default_nettype wire

//--- test/gpps_top_monitor.sv
`default_nettype none
module gpps_top_monitor (
   input wire logic core_clk,
   input wire logic nrst,
   input wire gpps_pkg::gpps_req_type req,
   input wire logic rvalid_q,
   input wire gpps_pkg::gpps_pin_type p0_pin_q,
   input wire gpps_pkg::gpps_pin_type p2_pin_q,
   input wire gpps_pkg::gpps_pin_type p3_pin_q,
   input wire logic [7:0] p4_in,
   input wire logic key_interrupt_clr,
   input wire logic key_interrupt_flag_q
);
   import gpps_pkg::*;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   rd_valid_a: assert property (req.rd |=> rvalid_q)
      else $error("read without valid");
   rd_idle_a: assert property (!req.rd |=> !rvalid_q)
      else $error("valid without read");
   p0_dir_a: assert property ((req.wr && !req.bit_mode && req.port == 3'h0
      && req.reg_sel == 2'h1 ##1 !req.wr) |=> p0_pin_q.oe_n[3:0] == $past(req.wdata[3:0], 2))
      else $error("port 0 direction not at pins");
   p0_hi_a: assert property ($past(nrst, 2) |-> p0_pin_q.oe_n[7:4] == 4'hf)
      else $error("port 0 absent bit driven");
   p2_pu_a: assert property ((req.wr && !req.bit_mode && req.port == 3'h2
      && req.reg_sel == 2'h2 ##1 !req.wr) |=> p2_pin_q.pu_en[5:0] == $past(req.wdata[5:0], 2))
      else $error("port 2 pull-up not at pins");
   p3_od_a: assert property ((~p3_pin_q.oe_n[1:0] & p3_pin_q.out_val[1:0]) == 2'h0)
      else $error("open-drain line driven high");
   key_set_a: assert property ((|($past(p4_in) & ~p4_in)) |-> ##[1:4] key_interrupt_flag_q)
      else $error("falling edge missed");
   key_hold_a: assert property (key_interrupt_flag_q && !key_interrupt_clr |=>
      key_interrupt_flag_q) else $error("key flag lost");
endmodule : gpps_top_monitor
bind gpps_top gpps_top_monitor mon (.core_clk, .nrst, .req, .rvalid_q, .p0_pin_q, .p2_pin_q,
   .p3_pin_q, .p4_in, .key_interrupt_clr, .key_interrupt_flag_q);
`default_nettype wire

//--- test/tb.sv
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import gpps_pkg::*;
   logic core_clk = 1'h0;
   logic nrst = 1'h0;
   gpps_req_type req = '0;
   logic [7:0] rdata_q;
   logic [7:0] an_q;
   logic [7:0] p1_in = 8'ha5;
   logic [7:0] p4_in = 8'hff;
   logic [3:0] p0_in;
   logic [5:0] p2_in;
   logic [6:0] p3_in = 7'h55;
   logic [7:0] p5_in = 8'h3c;
   logic [3:0] p6_in = 4'h9;
   logic [5:0] p7_in = 6'h2d;
   logic [3:0] ext_q;
   logic rvalid_q;
   logic kclr = 1'h0;
   logic kflag;
   gpps_pin_type p0_q, p2_q, p3_q, p4_q, p5_q, p6_q, p7_q;
   int failures = 0;
   int checked = 0;
   int n_ext = 0;
   always #2.5 core_clk = ~core_clk;
   always @(negedge core_clk) if (ext_q[0] === 1'h1) n_ext++;
   gpps_top dut (.core_clk, .nrst, .req, .rdata_q, .rvalid_q, .p0_in, .p1_in, .p2_in,
      .p3_in, .p4_in, .p5_in, .p6_in, .p7_in, .p0_pin_q(p0_q),
      .p2_pin_q(p2_q), .p3_pin_q(p3_q), .p4_pin_q(p4_q), .p5_pin_q(p5_q), .p6_pin_q(p6_q),
      .p7_pin_q(p7_q), .analog_inputs_q(an_q), .ext_interrupt_req_q(ext_q),
      .key_interrupt_clr(kclr), .key_interrupt_flag_q(kflag));
   gpps_pins_model #(.W(4)) m0 (.core_clk, .pin(p0_q), .ext_en(4'he), .ext_val(4'h0),
      .lvl(p0_in));
   gpps_pins_model #(.W(6)) m2 (.core_clk, .pin(p2_q), .ext_en(6'h00), .ext_val(6'h00),
      .lvl(p2_in));
   ////////////////////////////////////////////////////////////////////////////////
   task chk(input logic [7:0] s, input logic [7:0] e);
      checked++;
      if (s !== e) begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   // one idle cycle after each request keeps every signal to one change per step
   task acc(input logic w, input logic b, input logic [2:0] p, input logic [1:0] r,
      input logic [2:0] i, input logic [7:0] d);
      req = '{w, ~w, b, p, r, i, d};
      @(negedge core_clk);
      req = '0;
      @(negedge core_clk);
   endtask : acc
   task rd(input logic b, input logic [2:0] p, input logic [1:0] r, input logic [2:0] i,
      input logic [7:0] e);
      req = '{1'h0, 1'h1, b, p, r, i, 8'h00};
      @(negedge core_clk);
      // valid stands for one cycle only, so it is judged here
      chk({7'h00, rvalid_q}, 8'h01);
      chk(rdata_q, e);
      req = '0;
      @(negedge core_clk);
      chk({7'h00, rvalid_q}, 8'h00);
   endtask : rd
   ////////////////////////////////////////////////////////////////////////////////
   task t_rst;
      rd(1'h0, 3'h0, 2'h1, 3'h0, 8'hff);
      rd(1'h0, 3'h2, 2'h2, 3'h0, 8'h00);
      chk(p0_q.oe_n, 8'hff);
      chk(p2_q.oe_n, 8'hff);
      chk(p3_q.oe_n, 8'hff);
      chk(p5_q.oe_n, 8'hff);
      $display("t_rst done");
   endtask : t_rst
   task t_ports;
      rd(1'h0, 3'h3, 2'h0, 3'h0, 8'h55);
      rd(1'h0, 3'h4, 2'h0, 3'h0, 8'hff);
      rd(1'h0, 3'h5, 2'h0, 3'h0, 8'h3c);
      rd(1'h0, 3'h6, 2'h0, 3'h0, 8'h90);
      rd(1'h0, 3'h7, 2'h0, 3'h0, 8'h2d);
      acc(1'h1, 1'h0, 3'h6, 2'h1, 3'h0, 8'h00);
      chk(p6_q.oe_n, 8'h0f);
      chk(p7_q.oe_n, 8'hff);
      chk(p4_q.oe_n, 8'hff);
      $display("t_ports done");
   endtask : t_ports
   task t_p1;
      acc(1'h1, 1'h0, 3'h1, 2'h0, 3'h0, 8'h00);
      rd(1'h0, 3'h1, 2'h0, 3'h0, 8'ha5);
      rd(1'h1, 3'h1, 2'h0, 3'h2, 8'h01);
      chk(an_q, 8'ha5);
      $display("t_p1 done");
   endtask : t_p1
   task t_p0;
      acc(1'h1, 1'h0, 3'h0, 2'h1, 3'h0, 8'h0e);
      chk(p0_q.oe_n, 8'hfe);
      acc(1'h1, 1'h1, 3'h0, 2'h0, 3'h0, 8'h01);
      repeat (3) @(negedge core_clk);
      chk(n_ext[7:0], 8'h01);
      rd(1'h0, 3'h0, 2'h0, 3'h0, 8'h01);
      rd(1'h1, 3'h0, 2'h1, 3'h0, 8'h00);
      acc(1'h1, 1'h1, 3'h0, 2'h0, 3'h0, 8'h01);
      repeat (3) @(negedge core_clk);
      chk(n_ext[7:0], 8'h01);
      $display("t_p0 done");
   endtask : t_p0
   task t_p2;
      acc(1'h1, 1'h0, 3'h2, 2'h2, 3'h0, 8'hff);
      chk(p2_q.pu_en, 8'h3f);
      repeat (3) @(negedge core_clk);
      rd(1'h0, 3'h2, 2'h0, 3'h0, 8'h3f);
      $display("t_p2 done");
   endtask : t_p2
   task t_p3;
      acc(1'h1, 1'h0, 3'h3, 2'h2, 3'h0, 8'hff);
      rd(1'h0, 3'h3, 2'h2, 3'h0, 8'h70);
      acc(1'h1, 1'h0, 3'h3, 2'h0, 3'h0, 8'hff);
      acc(1'h1, 1'h0, 3'h3, 2'h1, 3'h0, 8'h00);
      chk(~p3_q.oe_n & p3_q.out_val & 8'h0f, 8'h00);
      chk(~p3_q.oe_n & p3_q.out_val & 8'h70, 8'h70);
      $display("t_p3 done");
   endtask : t_p3
   task t_key;
      chk({7'h00, kflag}, 8'h00);
      p4_in = 8'hef;
      repeat (5) @(negedge core_clk);
      chk({7'h00, kflag}, 8'h01);
      kclr = 1'h1;
      @(negedge core_clk);
      kclr = 1'h0;
      chk({7'h00, kflag}, 8'h00);
      p4_in = 8'hff;
      repeat (5) @(negedge core_clk);
      chk({7'h00, kflag}, 8'h00);
      $display("t_key done");
   endtask : t_key
   ////////////////////////////////////////////////////////////////////////////////
   task finish_test;
      $display("checked=%0d failures=%0d", checked, failures);
      if (failures == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : finish_test
   initial begin
      repeat (5) @(negedge core_clk);
      nrst = 1'h1;
      @(negedge core_clk);
      t_rst();
      t_ports();
      t_p1();
      t_p0();
      t_p2();
      t_p3();
      t_key();
      finish_test();
   end
   // the whole sequence needs well under a thousand cycles
   initial begin
      #5000;
      failures++;
      finish_test();
   end
endmodule : tb
`default_nettype wire
